// *** design/haptic_adc_event_flags.sv ***
/*
 * Event flag, mask and status logic of the haptic driver and converter monitor.
 * Assumes status inputs come from logic on core_clk and that register reads and
 * writes arrive as one-cycle strobes from the serial register interface.
 */
// Notes on behaviour
// [R1] Converter active status reads 1 only while enabled and converting.
// [R2] First flag bits 7..2 set when their fault status changes.
// [R3] First flag bit 1 sets on any change of clock-running status.
// [R4] First flag bit 0 sets on any change of resonance lock status.
// [R5] Second flag bit 2 sets on vibration timeout; driver then locked.
// [R6] Second flag bit 1 sets on supply undervoltage; driver then locked.
// [R7] Second flag bit 0 sets on any change of combined fault status.
// [R8] Third flag bit 1 follows converter activity changes; bit 0 end of conversion.
// [R9] Each flag has a mask bit; 1 passes it to the interrupt, 0 blocks.
// [R10] Combined fault status is 1 while any fault locks the driver.
// [R11] Flags stay set until software clears them by writing 1.
`timescale 1ns/1ps

module haptic_adc_event_flags (
    input wire logic core_clk,
    input wire logic reset,
    input haptic_flags_pkg::reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    input haptic_flags_pkg::haptic_status_t haptic_status,
    input wire logic tuning_done,
    input wire logic timeout_expired,
    input wire logic supply_undervoltage,
    input wire logic fault_release,
    input wire logic converter_enable,
    input wire logic conversion_running,
    input wire logic conversion_done,
    output logic irq,
    output logic haptic_lock
);

    logic [7:0] mask_a_q;
    logic [7:0] mask_a_d;
    logic [3:0] mask_b_q;
    logic [3:0] mask_b_d;
    logic [1:0] mask_c_q;
    logic [1:0] mask_c_d;
    logic lock_latched_q;
    logic lock_latched_d;
    logic combined_fault_q;
    logic combined_fault_d;
    logic converter_active_q;
    logic converter_active_d;
    logic irq_q;
    logic irq_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic [7:0] flags_a;
    logic [3:0] flags_b;
    logic [1:0] flags_c;
    logic [7:0] clear_a;
    logic [3:0] clear_b;
    logic [1:0] clear_c;
    logic [3:0] pulse_b;
    logic [1:0] pulse_c;
    logic fault_levels;

    // Write-one-to-clear strobes for each flag register
    always_comb begin
        clear_a = '0;
        clear_b = '0;
        clear_c = '0;
        if (reg_req.wr && reg_req.addr == haptic_flags_pkg::HAPTIC_EVENT_FLAGS_A_OFS) begin
            clear_a = reg_req.wdata; // see [R11]
        end else if (reg_req.wr
                && reg_req.addr == haptic_flags_pkg::HAPTIC_EVENT_FLAGS_B_OFS) begin
            clear_b = reg_req.wdata[3:0]; // see [R11]
        end else if (reg_req.wr
                && reg_req.addr == haptic_flags_pkg::CONVERTER_EVENT_FLAGS_OFS) begin
            clear_c = reg_req.wdata[1:0]; // see [R11]
        end
    end

    // Event pulses for flags that are not change-driven
    always_comb begin
        pulse_b = '0;
        pulse_b[haptic_flags_pkg::TUNING_DONE_BIT] = tuning_done;
        pulse_b[haptic_flags_pkg::TIMEOUT_BIT] = timeout_expired; // see [R5]
        pulse_b[haptic_flags_pkg::UNDERVOLTAGE_BIT] = supply_undervoltage; // see [R6]
        pulse_c = '0;
        pulse_c[haptic_flags_pkg::CONVERSION_DONE_BIT] = conversion_done; // see [R8]
    end

    // First bank watches all level status bits on change
    event_flag_bank #(.WIDTH(haptic_flags_pkg::FLAGS_A_WIDTH)) bank_a (
        .core_clk(core_clk),
        .reset(reset),
        .watch(haptic_status), // see [R2] see [R3] see [R4]
        .pulse('0),
        .clear(clear_a),
        .flags(flags_a)
    );

    // Second bank: combined fault changes plus pulsed tuning-done and fault events
    event_flag_bank #(.WIDTH(haptic_flags_pkg::FLAGS_B_WIDTH)) bank_b (
        .core_clk(core_clk),
        .reset(reset),
        .watch({3'h0, combined_fault_q}), // see [R7]
        .pulse(pulse_b),
        .clear(clear_b),
        .flags(flags_b)
    );

    // Third bank: converter activity changes and end of conversion
    event_flag_bank #(.WIDTH(haptic_flags_pkg::FLAGS_C_WIDTH)) bank_c (
        .core_clk(core_clk),
        .reset(reset),
        .watch({converter_active_q, 1'b0}), // see [R8]
        .pulse(pulse_c),
        .clear(clear_c),
        .flags(flags_c)
    );

    // Fault lock, combined fault status, converter activity and interrupt
    always_comb begin
        fault_levels = |haptic_status[7:2];
        lock_latched_d = lock_latched_q;
        if (timeout_expired || supply_undervoltage) begin
            lock_latched_d = 1'b1; // see [R5] see [R6]
        end else if (fault_release) begin
            lock_latched_d = 1'b0;
        end
        combined_fault_d = lock_latched_d | fault_levels; // see [R10]
        converter_active_d = converter_enable & conversion_running; // see [R1]
        irq_d = |{flags_a & mask_a_q, flags_b & mask_b_q, flags_c & mask_c_q}; // see [R9]
    end

    // Mask writes and registered read data
    always_comb begin
        mask_a_d = mask_a_q;
        mask_b_d = mask_b_q;
        mask_c_d = mask_c_q;
        if (reg_req.wr && reg_req.addr == haptic_flags_pkg::HAPTIC_MASK_A_OFS) begin
            mask_a_d = reg_req.wdata;
        end else if (reg_req.wr && reg_req.addr == haptic_flags_pkg::HAPTIC_MASK_B_OFS) begin
            mask_b_d = reg_req.wdata[3:0];
        end else if (reg_req.wr && reg_req.addr == haptic_flags_pkg::CONVERTER_MASK_OFS) begin
            mask_c_d = reg_req.wdata[1:0];
        end
        rdata_d = rdata_q;
        if (reg_req.rd) begin
            rdata_d = haptic_flags_pkg::READ_ZERO;
            if (reg_req.addr == haptic_flags_pkg::HAPTIC_STATUS_A_OFS) begin
                rdata_d = haptic_status;
            end else if (reg_req.addr == haptic_flags_pkg::HAPTIC_STATUS_B_OFS) begin
                rdata_d[haptic_flags_pkg::FAULT_STATUS_BIT] = combined_fault_q;
            end else if (reg_req.addr == haptic_flags_pkg::CONVERTER_STATUS_OFS) begin
                rdata_d[haptic_flags_pkg::CONVERTER_ACTIVE_BIT] = converter_active_q;
            end else if (reg_req.addr == haptic_flags_pkg::HAPTIC_EVENT_FLAGS_A_OFS) begin
                rdata_d = flags_a;
            end else if (reg_req.addr == haptic_flags_pkg::HAPTIC_EVENT_FLAGS_B_OFS) begin
                rdata_d[3:0] = flags_b;
            end else if (reg_req.addr == haptic_flags_pkg::CONVERTER_EVENT_FLAGS_OFS) begin
                rdata_d[1:0] = flags_c;
            end else if (reg_req.addr == haptic_flags_pkg::HAPTIC_MASK_A_OFS) begin
                rdata_d = mask_a_q;
            end else if (reg_req.addr == haptic_flags_pkg::HAPTIC_MASK_B_OFS) begin
                rdata_d[3:0] = mask_b_q;
            end else if (reg_req.addr == haptic_flags_pkg::CONVERTER_MASK_OFS) begin
                rdata_d[1:0] = mask_c_q;
            end
        end
    end

    // State registers
    always_ff @(posedge core_clk) begin
        if (reset) begin
            mask_a_q <= haptic_flags_pkg::MASK_A_RESET;
            mask_b_q <= haptic_flags_pkg::MASK_B_RESET;
            mask_c_q <= haptic_flags_pkg::MASK_C_RESET;
            lock_latched_q <= 1'b0;
            combined_fault_q <= 1'b0;
            converter_active_q <= 1'b0;
            irq_q <= 1'b0;
            rdata_q <= haptic_flags_pkg::READ_ZERO;
        end else begin
            mask_a_q <= mask_a_d;
            mask_b_q <= mask_b_d;
            mask_c_q <= mask_c_d;
            lock_latched_q <= lock_latched_d;
            combined_fault_q <= combined_fault_d;
            converter_active_q <= converter_active_d;
            irq_q <= irq_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign irq = irq_q;
    assign haptic_lock = combined_fault_q;

    // Checks on flag, lock and interrupt behaviour
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    // Clearing write to the first flag register that targets its top bit
    sequence clear_a_write_s;
        reg_req.wr && reg_req.addr == haptic_flags_pkg::HAPTIC_EVENT_FLAGS_A_OFS
            && reg_req.wdata[7];
    endsequence

    // No fresh change of the supply disable level in the same cycle
    sequence supply_quiet_s;
        !$changed(haptic_status.supply_disable);
    endsequence

    busy_status_a: assert property (##1 converter_active_q // see [R1]
        == $past(converter_enable && conversion_running))
        else $error("converter active status wrong");
    supply_flag_set_a: assert property ($changed(haptic_status.supply_disable) // see [R2]
        |=> flags_a[7])
        else $error("supply disable change not flagged");
    thermal_flag_set_a: assert property ($changed(haptic_status.thermal_status) // see [R2]
        |=> flags_a[2])
        else $error("thermal change not flagged");
    clock_flag_set_a: assert property ($changed(haptic_status.clock_running_status) // see [R3]
        |=> flags_a[1])
        else $error("clock running change not flagged");
    lock_flag_set_a: assert property ($changed(haptic_status.resonance_lock_status) // see [R4]
        |=> flags_a[0])
        else $error("resonance lock change not flagged");
    timeout_locks_a: assert property (timeout_expired |=> flags_b[2] && haptic_lock) // see [R5]
        else $error("timeout not flagged or not locked");
    uvlo_locks_a: assert property (supply_undervoltage |=> flags_b[1] && haptic_lock) // see [R6]
        else $error("undervoltage not flagged or not locked");
    fault_change_flag_a: assert property ($changed(combined_fault_q) |=> flags_b[0]) // see [R7]
        else $error("combined fault change not flagged");
    busy_change_flag_a: assert property ($changed(converter_active_q) |=> flags_c[1]) // see [R8]
        else $error("converter activity change not flagged");
    irq_gating_a: assert property (##1 irq == ($past(|(flags_a & mask_a_q)) // see [R9]
        || $past(|(flags_b & mask_b_q)) || $past(|(flags_c & mask_c_q))))
        else $error("interrupt not following masked flags");
    fault_status_a: assert property (|haptic_status[7:2] |=> haptic_lock) // see [R10]
        else $error("fault level without combined fault");
    flag_sticky_a: assert property (flags_a[7] && !clear_a[7] |=> flags_a[7]) // see [R11]
        else $error("flag dropped without clear");
    flag_clear_a: assert property (clear_a_write_s ##0 supply_quiet_s |=> !flags_a[7]) // see [R11]
        else $error("flag not cleared by write");

endmodule

// *** design/haptic_flags_pkg.sv ***
/*
 * Shared constants and carrier types for the haptic and converter event flag block.
 * Assumes one core clock domain; register accesses arrive already decoded from the
 * device's serial register interface as single-cycle read and write strobes.
 */
package haptic_flags_pkg;

    // Register offsets
    localparam logic [7:0] HAPTIC_STATUS_A_OFS = 8'h00;
    localparam logic [7:0] HAPTIC_STATUS_B_OFS = 8'h01;
    localparam logic [7:0] CONVERTER_STATUS_OFS = 8'h02;
    localparam logic [7:0] HAPTIC_EVENT_FLAGS_A_OFS = 8'h03;
    localparam logic [7:0] HAPTIC_EVENT_FLAGS_B_OFS = 8'h04;
    localparam logic [7:0] CONVERTER_EVENT_FLAGS_OFS = 8'h05;
    localparam logic [7:0] HAPTIC_MASK_A_OFS = 8'h06;
    localparam logic [7:0] HAPTIC_MASK_B_OFS = 8'h07;
    localparam logic [7:0] CONVERTER_MASK_OFS = 8'h08;

    // Field positions
    localparam int FAULT_STATUS_BIT = 0;
    localparam int CONVERTER_ACTIVE_BIT = 1;
    localparam int TUNING_DONE_BIT = 3;
    localparam int TIMEOUT_BIT = 2;
    localparam int UNDERVOLTAGE_BIT = 1;
    localparam int COMBINED_FAULT_BIT = 0;
    localparam int CONVERSION_DONE_BIT = 0;

    // Widths of the flag banks
    localparam int FLAGS_A_WIDTH = 8;
    localparam int FLAGS_B_WIDTH = 4;
    localparam int FLAGS_C_WIDTH = 2;

    // Values after reset
    localparam logic [7:0] MASK_A_RESET = 8'h00;
    localparam logic [3:0] MASK_B_RESET = 4'h0;
    localparam logic [1:0] MASK_C_RESET = 2'h0;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // Level status bits watched in the first flag register, bit order as read
    typedef struct packed {
        logic supply_disable;
        logic pos_low_overcurrent;
        logic neg_low_overcurrent;
        logic pos_high_overcurrent;
        logic neg_high_overcurrent;
        logic thermal_status;
        logic clock_running_status;
        logic resonance_lock_status;
    } haptic_status_t;

    // One register access from the serial register interface
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

endpackage

// *** design/event_flag_bank.sv ***
/*
 * A bank of sticky event flags: a flag sets on a change of its watched level or on a
 * pulse, and clears when software writes 1 to it. Set wins over a clear in the same cycle.
 * Assumes watch and pulse are on core_clk, so no synchronisers are needed.
 */
`timescale 1ns/1ps

module event_flag_bank #(
    parameter int WIDTH = 8
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] watch,
    input wire logic [WIDTH-1:0] pulse,
    input wire logic [WIDTH-1:0] clear,
    output logic [WIDTH-1:0] flags
);

    logic [WIDTH-1:0] prev_q;
    logic [WIDTH-1:0] prev_d;
    logic [WIDTH-1:0] flags_q;
    logic [WIDTH-1:0] flags_d;

    // Change detection and write-one-to-clear, set taking priority
    always_comb begin
        prev_d = watch;
        flags_d = (flags_q & ~clear) | (watch ^ prev_q) | pulse;
    end

    // Previous level is taken from the watched value during reset, so no spurious flag
    always_ff @(posedge core_clk) begin
        if (reset) begin
            prev_q <= watch;
            flags_q <= '0;
        end else begin
            prev_q <= prev_d;
            flags_q <= flags_d;
        end
    end

    assign flags = flags_q;

endmodule

// *** tb/host_model.sv ***
/*
 * Host processor model: issues decoded register reads and writes to the flag block.
 * Assumes the block takes a strobe at a rising edge and answers one cycle later.
 */
`timescale 1ns/1ps

module host_model (
    input wire logic core_clk,
    output haptic_flags_pkg::reg_req_t reg_req,
    input wire logic [7:0] reg_rdata
);
    initial begin
        reg_req = '0;
    end

    // Write strobe held for one taking edge; released lines show inverted values
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        #1;
        reg_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge core_clk);
        #1;
        reg_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    endtask

    // Read strobe; data taken after the answering edge has landed
    task automatic get(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        #1;
        reg_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(posedge core_clk);
        #1;
        reg_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hFF};
        d = reg_rdata;
    endtask
endmodule

// *** tb/haptic_adc_event_flags_tb.sv ***
/*
 * Self-checking bench for the haptic and converter event flag block.
 * Assumes the host model drives the register port; status and events come from here.
 */
`timescale 1ns/1ps

module haptic_adc_event_flags_tb;
    typedef struct packed {
        logic [7:0] st;
        logic [4:0] pl;
        logic [1:0] er;
        logic [7:0] ea;
        logic [7:0] eb;
        logic [7:0] ec;
        logic lk;
    } row_t;

    logic core_clk = 1'b0;
    logic reset = 1'b1;
    haptic_flags_pkg::reg_req_t reg_req;
    logic [7:0] reg_rdata;
    logic [7:0] st = 8'h00;
    logic [4:0] pl = 5'h00;
    logic [1:0] er = 2'h0;
    logic irq;
    logic haptic_lock;
    logic [7:0] rd;
    logic [7:0] exp_v [6];
    int err_total = 0;
    int checks_done = 0;
    // Status levels, pulses {tune, timeout, uvlo, release, done}, {enable, running}
    row_t rows [13] = '{
        '{8'h04, 5'h00, 2'h0, 8'h04, 8'h01, 8'h00, 1'h1},
        '{8'h00, 5'h00, 2'h0, 8'h04, 8'h01, 8'h00, 1'h0},
        '{8'h03, 5'h00, 2'h0, 8'h03, 8'h00, 8'h00, 1'h0},
        '{8'hF8, 5'h00, 2'h0, 8'hFB, 8'h01, 8'h00, 1'h1},
        '{8'h00, 5'h10, 2'h0, 8'hF8, 8'h09, 8'h00, 1'h0},
        '{8'h00, 5'h08, 2'h0, 8'h00, 8'h05, 8'h00, 1'h1},
        '{8'h00, 5'h02, 2'h0, 8'h00, 8'h01, 8'h00, 1'h0},
        '{8'h00, 5'h04, 2'h0, 8'h00, 8'h03, 8'h00, 1'h1},
        '{8'h00, 5'h02, 2'h0, 8'h00, 8'h01, 8'h00, 1'h0},
        '{8'h00, 5'h00, 2'h2, 8'h00, 8'h00, 8'h00, 1'h0},
        '{8'h00, 5'h00, 2'h3, 8'h00, 8'h00, 8'h02, 1'h0},
        '{8'h00, 5'h01, 2'h3, 8'h00, 8'h00, 8'h01, 1'h0},
        '{8'h00, 5'h00, 2'h1, 8'h00, 8'h00, 8'h02, 1'h0}};

    // Clock at 50 MHz
    always #10 core_clk = ~core_clk;

    host_model host (.core_clk(core_clk), .reg_req(reg_req), .reg_rdata(reg_rdata));

    haptic_adc_event_flags u_dut (
        .core_clk(core_clk),
        .reset(reset),
        .reg_req(reg_req),
        .reg_rdata(reg_rdata),
        .haptic_status(haptic_flags_pkg::haptic_status_t'(st)),
        .tuning_done(pl[4]),
        .timeout_expired(pl[3]),
        .supply_undervoltage(pl[2]),
        .fault_release(pl[1]),
        .converter_enable(er[1]),
        .conversion_running(er[0]),
        .conversion_done(pl[0]),
        .irq(irq),
        .haptic_lock(haptic_lock)
    );

    // Compare and count
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
        checks_done++;
        if (seen !== want) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, want, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // Watchdog
    initial begin
        #200000;
        err_total++;
        conclude();
    end

    initial begin
        settle(2);
        reset = 1'b0;
        check("rdata at reset", reg_rdata, 8'h00);
        check("irq at reset", {7'h0, irq}, 8'h00);
        foreach (rows[i]) begin
            st = rows[i].st;
            pl = rows[i].pl;
            er = rows[i].er;
            settle(1);
            pl = 5'h00;
            settle(4);
            check("lock", {7'h0, haptic_lock}, {7'h0, rows[i].lk});
            exp_v = '{rows[i].st, {7'h0, rows[i].lk}, {6'h0, &rows[i].er, 1'b0},
                      rows[i].ea, rows[i].eb, rows[i].ec};
            for (int a = 0; a < 6; a++) begin
                host.get(8'(a), rd);
                check("reg", rd, exp_v[a]);
            end
            for (int a = 3; a < 6; a++) begin
                host.put(8'(a), 8'hFF);
            end
        end
        // Masked flag stays off the interrupt until unmasked, then clears
        st = 8'h04;
        settle(4);
        check("irq masked", {7'h0, irq}, 8'h00);
        host.put(8'h06, 8'h04);
        settle(2);
        check("irq open", {7'h0, irq}, 8'h01);
        host.get(8'h06, rd);
        check("mask readback", rd, 8'h04);
        host.put(8'h03, 8'h04);
        settle(2);
        check("irq cleared", {7'h0, irq}, 8'h00);
        // Second and third banks reach the interrupt only through their own masks
        host.put(8'h07, 8'h01);
        settle(2);
        check("irq mask b", {7'h0, irq}, 8'h01);
        host.put(8'h07, 8'h00);
        pl = 5'h01;
        settle(1);
        pl = 5'h00;
        host.put(8'h08, 8'h01);
        settle(2);
        check("irq mask c", {7'h0, irq}, 8'h01);
        host.put(8'h08, 8'h00);
        settle(2);
        check("irq mask c off", {7'h0, irq}, 8'h00);
        // New change at the edge of a clearing write keeps the flag
        fork
            host.put(8'h03, 8'h04);
            begin
                @(posedge core_clk);
                #1;
                st = 8'h00;
            end
        join
        settle(3);
        host.get(8'h03, rd);
        check("set over clear", rd, 8'h04);
        // Unmapped and read-only places ignore writes
        host.put(8'h20, 8'hFF);
        host.get(8'h20, rd);
        check("unmapped", rd, 8'h00);
        host.put(8'h00, 8'hFF);
        host.get(8'h00, rd);
        check("status ro", rd, 8'h00);
        // Reset in mid-run with a fault level present
        st = 8'h04;
        reset = 1'b1;
        settle(2);
        reset = 1'b0;
        settle(3);
        host.get(8'h06, rd);
        check("mask after reset", rd, 8'h00);
        host.get(8'h03, rd);
        check("flags after reset", rd, 8'h00);
        check("irq after reset", {7'h0, irq}, 8'h00);
        conclude();
    end
endmodule
